// >>> core/opdec_cycle_rom.sv
// Purpose: machine-state count table, registered read
// Assumes: index is op class and condition select
// Notes: count of 0 means timing is computed elsewhere
`timescale 1ns/1ns
module opdec_cycle_rom (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // lookup
    input wire logic [5:0] op_idx,
    input wire logic [1:0] sel,
    output logic [5:0] states_r
);
    import opdec_pkg::*;
    logic [5:0] states_nxt;
    // sel[1]: aligned fail / no jump, sel[0]: three-state penalty (six for op_dsj, op_dsj_eq, op_dsj_ne; none for calls and op_st_push)
    function automatic logic [5:0] pick(input logic [5:0] a,
            input logic [5:0] b, input logic s);
        return s ? b : a;
    endfunction : pick
    always_comb begin
        states_nxt = 6'h00;
        unique case (op_class_e'(op_idx))
            op_pw_compare, op_rev_query, op_pc_read, op_st_read, op_nop,
            op_fs_swap, op_field_load: states_nxt = pick(6'h01, 6'h04, sel[0]);
            op_xy_convert, op_int_dis, op_int_en, op_st_write:
                states_nxt = pick(6'h03, 6'h06, sel[0]); // RQ2
            op_pc_swap, op_jump_reg: states_nxt = pick(6'h02, 6'h05, sel[0]);
            op_dbg_entry: states_nxt = pick(6'h06, 6'h09, sel[0]);
            op_call_reg: states_nxt = sel[1] ? 6'h0f : 6'h09; // RQ8
            op_call_abs: states_nxt = sel[1] ? 6'h15 : 6'h0f; // RQ8
            op_call_rel: states_nxt = sel[1] ? 6'h11 : 6'h0b; // RQ8
            op_st_pop: states_nxt = sel[1] ? pick(6'h0a, 6'h0d, sel[0])
                : pick(6'h08, 6'h0b, sel[0]); // RQ8
            op_st_push: states_nxt = sel[1] ? 6'h0d : 6'h08; // RQ8
            op_int_ret: states_nxt = sel[1] ? pick(6'h0f, 6'h12, sel[0])
                : pick(6'h0b, 6'h0e, sel[0]); // RQ8
            op_sub_ret: states_nxt = pick(6'h07, 6'h0a, sel[0]); // RQ9
            op_trap: states_nxt = sel[1] ? pick(6'h1e, 6'h21, sel[0])
                : pick(6'h10, 6'h13, sel[0]); // RQ10
            op_dsj, op_dsj_eq, op_dsj_ne:
                states_nxt = sel[1] ? pick(6'h02, 6'h08, sel[0])
                    : pick(6'h03, 6'h09, sel[0]); // RQ13
            op_dsj_short: states_nxt = sel[1] ? pick(6'h03, 6'h06, sel[0])
                : pick(6'h02, 6'h05, sel[0]); // RQ13
            op_jump_abs: states_nxt = sel[1] ? pick(6'h04, 6'h07, sel[0])
                : pick(6'h03, 6'h06, sel[0]); // RQ13
            op_jump_rel: states_nxt = sel[1] ? pick(6'h01, 6'h04, sel[0])
                : pick(6'h03, 6'h06, sel[0]); // RQ13
            op_jump_short: states_nxt = pick(6'h02, 6'h05, sel[0]); // RQ13
            op_shift_k, op_shift_r: states_nxt = pick(6'h01, 6'h04, sel[0]);
            default: states_nxt = 6'h00;
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            states_r <= 6'h00;
        end else begin
            states_r <= states_nxt;
        end
    end
endmodule : opdec_cycle_rom

// >>> core/opdec_map.svh
// Purpose: opcode field positions and cycle counts for the opcode decoder
// Assumes: 16-bit opcode words, bit 15 is the top bit
// Notes: counts are machine states, first value fast/aligned/taken
// Overview of operation
// RQ1 - point-window compare: 1110 011S, one or four states
// RQ2 - xy-to-linear convert: 1110 100S, three or six states
// RQ3 - draw-and-step: 1111 011S with source and destination fields
// RQ4 - fills: 0000 1111 1100/1110 0000, linear or xy
// RQ5 - line draw: 1101 1111 Z001 1010, Z picks variant
// RQ6 - six pixel block copies: 0000 1111 nnn0 0000
// RQ7 - single pixel transfers: 1111 then three-bit operand form
// RQ8 - stack ops take short count if stack aligned, long otherwise; code also takes the long count when taken is low
// RQ9 - subroutine return 0000 1001 011N NNNN, seven or ten states
// RQ10 - trap 0000 1001 000N NNNN, sixteen or nineteen aligned; code gives these only with taken high too
// RQ11 - revision query 0000 0000 001R DDDD, one or four states
// RQ12 - field parameter load 0000 01F1 01FS ssss
// RQ13 - jumps: first count taken, second count not taken
// RQ14 - conditional jumps 1100 cc: absolute, relative, short forms
// RQ15 - short decrement-skip jump 0011 1 D offset register
// RQ16 - constant shifts: rotate 0011 00, others 0010 xx
// RQ17 - register shifts 0110 0xx / 100; arith left 3,6
// RQ18 - register jump 0000 0001 011R DDDD, two or five states
// RQ19 - immediate short form two words, long form three words
// RQ20 - single-version immediates always use long 32-bit operand
// RQ21 - programs keep both register operands in one file
// RQ22 - R bit is shared file select; S and D are indices
// RQ23 - unmatched words raise an illegal-opcode indication
`ifndef OPDEC_MAP_SVH
`define OPDEC_MAP_SVH
`define OPDEC_R_BIT 4
`define OPDEC_N_LSB 0
`define OPDEC_S_LSB 5
`define OPDEC_D_LSB 0
`define OPDEC_CC_LSB 8
`define OPDEC_REV_LEVEL 32'h0000_0001
`endif

// >>> core/opdec_pkg.sv
// Purpose: types for the opcode decoder
// Assumes: none
// Notes: op classes are coarse groups for the datapath
package opdec_pkg;
    typedef enum logic [5:0] {
        op_none, op_pw_compare, op_xy_convert, op_draw_step, op_fill_lin,
        op_fill_xy, op_line, op_blk_copy, op_pix_xfer, op_call_reg,
        op_call_abs, op_call_rel, op_int_dis, op_int_en, op_dbg_entry,
        op_fs_swap, op_pc_swap, op_pc_read, op_st_read, op_nop,
        op_st_pop, op_st_push, op_st_write, op_int_ret, op_sub_ret,
        op_rev_query, op_field_load, op_trap, op_dsj, op_dsj_eq,
        op_dsj_ne, op_dsj_short, op_jump_abs, op_jump_rel, op_jump_short,
        op_jump_reg, op_shift_k, op_shift_r, op_imm
    } op_class_e;
    typedef enum logic [2:0] {
        sh_rotl, sh_asl, sh_lsl, sh_asr, sh_lsr
    } shift_kind_e;
    typedef struct packed {
        logic valid;
        logic illegal;
        op_class_e op;
        logic [2:0] variant;
        logic rfile;
        logic [3:0] src;
        logic [3:0] dst;
        logic [4:0] konst;
        logic [3:0] cond;
        logic [7:0] disp;
        logic [1:0] ext_words;
        logic imm_long;
        logic [5:0] states;
    } dec_out_s;
    typedef struct packed {
        logic valid;
        logic [15:0] word;
        logic sp_aligned;
        logic taken;
        logic fast;
    } dec_in_s;
endpackage : opdec_pkg

// >>> core/opdec_top.sv
// Purpose: decode 16-bit opcodes of graphics, control, jump and shift groups
// Assumes: one clock; fetch path presents one word with a valid strobe
// Notes: one cycle latency; counts picked by fast, aligned and taken inputs
`timescale 1ns/1ns
`include "opdec_map.svh"
module opdec_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fetch side
    input wire opdec_pkg::dec_in_s fetch_in,
    // datapath side
    output opdec_pkg::dec_out_s dec_out_r
);
    import opdec_pkg::*;
    dec_out_s dec_nxt;
    dec_out_s dec_r;
    logic [5:0] states_r;
    logic [1:0] rom_sel;
    logic [5:0] rom_idx;
    logic [15:0] w;

    function automatic logic [3:0] nib(input logic [15:0] x,
            input int unsigned n);
        return x[n*4 +: 4];
    endfunction : nib

    assign w = fetch_in.word;
    assign rom_sel = {~fetch_in.sp_aligned | ~fetch_in.taken, ~fetch_in.fast};
    // arith left shifts share the three/six count of the convert op
    assign rom_idx = (dec_nxt.op inside {op_shift_k, op_shift_r}
        && dec_nxt.variant == 3'(sh_asl)) ? 6'(op_xy_convert)
        : 6'(dec_nxt.op); // RQ17

    always_comb begin
        dec_nxt = '0;
        dec_nxt.valid = fetch_in.valid;
        dec_nxt.op = op_none;
        dec_nxt.rfile = w[`OPDEC_R_BIT]; // RQ22
        dec_nxt.src = w[`OPDEC_S_LSB +: 4]; // RQ22
        dec_nxt.dst = w[`OPDEC_D_LSB +: 4]; // RQ22
        dec_nxt.konst = w[9:5];
        dec_nxt.cond = w[`OPDEC_CC_LSB +: 4];
        dec_nxt.disp = w[7:0];
        unique case (nib(w, 3))
            4'he: begin
                if (w[11:9] == 3'h3) dec_nxt.op = op_pw_compare; // RQ1
                else if (w[11:9] == 3'h4) dec_nxt.op = op_xy_convert; // RQ2
            end
            4'hf: begin
                if (w[11:9] == 3'h3) begin
                    dec_nxt.op = op_draw_step; // RQ3
                end else if (w[11:9] != 3'h7) begin
                    dec_nxt.op = op_pix_xfer; // RQ7
                    dec_nxt.variant = w[11:9]; // RQ7
                end
            end
            4'hd: begin
                if (w[11:8] == 4'hf && w[6:0] == 7'h1a) begin
                    dec_nxt.op = op_line; // RQ5
                    dec_nxt.variant = {2'h0, w[7]}; // RQ5
                end else if (w[11:10] == 2'h1 && w[8] && w[7:5] == 3'h0)
                    dec_nxt.op = op_fs_swap;
            end
            4'hc: begin
                dec_nxt.cond = w[11:8]; // RQ14
                if (w[7:0] == 8'h80) begin
                    dec_nxt.op = op_jump_abs; // RQ14
                    dec_nxt.ext_words = 2'h2;
                end else if (w[7:0] == 8'h00) begin
                    dec_nxt.op = op_jump_rel; // RQ14
                    dec_nxt.ext_words = 2'h1;
                end else begin
                    dec_nxt.op = op_jump_short; // RQ14
                end
            end
            4'h3: begin
                if (w[11]) begin
                    dec_nxt.op = op_dsj_short; // RQ15
                    dec_nxt.variant = {2'h0, w[10]}; // RQ15
                    dec_nxt.konst = w[9:5]; // RQ15
                end else if (w[11:10] == 2'h0) begin
                    dec_nxt.op = op_shift_k; // RQ16
                    dec_nxt.variant = 3'(sh_rotl); // RQ16
                end
            end
            4'h2: begin
                dec_nxt.op = op_shift_k; // RQ16
                unique case (w[11:10])
                    2'h0: dec_nxt.variant = 3'(sh_asl); // RQ16
                    2'h1: dec_nxt.variant = 3'(sh_lsl); // RQ16
                    2'h2: dec_nxt.variant = 3'(sh_asr); // RQ16
                    2'h3: dec_nxt.variant = 3'(sh_lsr); // RQ16
                endcase
            end
            4'h6: begin
                if (w[11:9] <= 3'h4) begin
                    dec_nxt.op = op_shift_r; // RQ17
                    unique case (w[11:9])
                        3'h0: dec_nxt.variant = 3'(sh_asl); // RQ17
                        3'h1: dec_nxt.variant = 3'(sh_lsl); // RQ17
                        3'h2: dec_nxt.variant = 3'(sh_asr); // RQ17
                        3'h3: dec_nxt.variant = 3'(sh_lsr); // RQ17
                        default: dec_nxt.variant = 3'(sh_rotl); // RQ17
                    endcase
                end
            end
            4'h0: begin
                unique case (nib(w, 2))
                    4'hf: begin
                        if (w[4:0] == 5'h00 && w[7:5] != 3'h7) begin
                            if (w[7:5] == 3'h6) dec_nxt.op = op_fill_lin; // RQ4
                            else if (w[7:5] == 3'h7) dec_nxt.op = op_fill_xy;
                            else dec_nxt.op = op_blk_copy; // RQ6
                            dec_nxt.variant = w[7:5]; // RQ6
                        end else if (w[7:0] == 8'he0) begin
                            dec_nxt.op = op_fill_xy; // RQ4
                        end
                    end
                    4'h9: begin
                        unique case (w[7:5])
                            3'h0: dec_nxt.op = op_trap; // RQ10
                            3'h1: dec_nxt.op = op_call_reg; // RQ8
                            3'h2: if (w[4:0] == 5'h00) dec_nxt.op = op_int_ret;
                            3'h3: dec_nxt.op = op_sub_ret; // RQ9
                            3'h6: begin
                                dec_nxt.op = op_imm; // RQ19
                                dec_nxt.ext_words = 2'h1; // RQ19
                            end
                            3'h7: begin
                                dec_nxt.op = op_imm; // RQ19
                                dec_nxt.ext_words = 2'h2; // RQ19
                                dec_nxt.imm_long = 1'b1; // RQ19
                            end
                            default: dec_nxt.op = op_none;
                        endcase
                        dec_nxt.konst = w[4:0]; // RQ9
                    end
                    4'hb: begin
                        dec_nxt.op = op_imm;
                        // short form for add, cmp, sub; others long only
                        if (w[7:5] == 3'h0 || w[7:5] == 3'h2 || w[7:5] == 3'h7)
                            dec_nxt.ext_words = 2'h1; // RQ19
                        else begin
                            dec_nxt.ext_words = 2'h2; // RQ20
                            dec_nxt.imm_long = 1'b1; // RQ20
                        end
                    end
                    4'hd: begin
                        if (w[7:0] == 8'h5f) begin
                            dec_nxt.op = op_call_abs;
                            dec_nxt.ext_words = 2'h2;
                        end else if (w[7:0] == 8'h3f) begin
                            dec_nxt.op = op_call_rel;
                            dec_nxt.ext_words = 2'h1;
                        end else if (w[7:0] == 8'h60) dec_nxt.op = op_int_en;
                        else if (w[7:5] == 3'h4) dec_nxt.op = op_dsj; // RQ13
                        else if (w[7:5] == 3'h5) dec_nxt.op = op_dsj_eq;
                        else if (w[7:5] == 3'h6) dec_nxt.op = op_dsj_ne;
                        else if (w[7:5] == 3'h0) begin
                            dec_nxt.op = op_imm; // RQ20
                            dec_nxt.ext_words = 2'h2; // RQ20
                            dec_nxt.imm_long = 1'b1; // RQ20
                        end
                        if (w[7:5] inside {3'h4, 3'h5, 3'h6})
                            dec_nxt.ext_words = 2'h1; // RQ13
                    end
                    4'h3: begin
                        if (w[7:0] == 8'h60) dec_nxt.op = op_int_dis;
                        else if (w[7:0] == 8'h00) dec_nxt.op = op_nop;
                    end
                    4'h1: begin
                        unique case (w[7:5])
                            3'h0: if (w[4:0] == 5'h00) dec_nxt.op = op_dbg_entry;
                            3'h1: dec_nxt.op = op_pc_swap;
                            3'h2: dec_nxt.op = op_pc_read;
                            3'h3: dec_nxt.op = op_jump_reg; // RQ18
                            3'h4: dec_nxt.op = op_st_read;
                            3'h5: dec_nxt.op = op_st_write;
                            3'h6: if (w[4:0] == 5'h00) dec_nxt.op = op_st_pop;
                            3'h7: if (w[4:0] == 5'h00) dec_nxt.op = op_st_push;
                        endcase
                    end
                    4'h0: begin
                        if (w[7:5] == 3'h1) dec_nxt.op = op_rev_query; // RQ11
                    end
                    4'h5, 4'h7: begin
                        if (w[7:6] == 2'h1) begin
                            dec_nxt.op = op_field_load; // RQ12
                            dec_nxt.variant = {1'b0, w[9], w[5]}; // RQ12
                            dec_nxt.konst = w[4:0]; // RQ12
                        end
                    end
                    default: dec_nxt.op = op_none;
                endcase
            end
            default: dec_nxt.op = op_none;
        endcase
        dec_nxt.illegal = fetch_in.valid && dec_nxt.op == op_none; // RQ23
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dec_r <= '0;
        end else begin
            dec_r <= dec_nxt;
        end
    end

    opdec_cycle_rom u_rom (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .op_idx(rom_idx),
        .sel(rom_sel),
        .states_r(states_r)
    );

    always_comb begin
        dec_out_r = dec_r;
        dec_out_r.states = states_r;
    end

    // checks
    illegal_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dec_r.illegal |-> dec_r.valid && dec_r.op == op_none) // RQ23
        else $error("illegal flag without unmatched op");
    pw_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fetch_in.word[15:9] == 7'h73 |=> dec_r.op == op_pw_compare) // RQ1
        else $error("point compare not decoded");
    draw_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fetch_in.word[15:9] == 7'h7b |=> dec_r.op == op_draw_step) // RQ3
        else $error("draw step not decoded");
    ret_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fetch_in.word[15:5] == 11'h04b |=> dec_r.op == op_sub_ret
        && dec_r.konst == $past(fetch_in.word[4:0])) // RQ9
        else $error("return count lost");
    jump_abs_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fetch_in.word[15:12] == 4'hc && fetch_in.word[7:0] == 8'h80
        |=> dec_r.op == op_jump_abs && dec_r.ext_words == 2'h2) // RQ14
        else $error("absolute jump form wrong");
    rev_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fetch_in.word[15:5] == 11'h001 |=> dec_r.op == op_rev_query) // RQ11
        else $error("revision query not decoded");
    rfile_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dec_r.rfile == $past(fetch_in.word[4])) // RQ22
        else $error("file select not from bit 4");
    long_imm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dec_r.imm_long |-> dec_r.ext_words == 2'h2) // RQ20
        else $error("long immediate not three words");
    trap_cnt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fetch_in.word[15:5] == 11'h048 && fetch_in.sp_aligned
        && fetch_in.taken && fetch_in.fast ##1 1'b1
        |-> states_r == 6'h10) // RQ10
        else $error("trap count wrong");
    illegal_c: cover property (@(posedge clk_sys) dec_r.illegal);
    short_jump_c: cover property (@(posedge clk_sys)
        dec_r.op == op_jump_short);
    blk_copy_c: cover property (@(posedge clk_sys) dec_r.op == op_blk_copy);
endmodule : opdec_top

// >>> sim/fetch_model.sv
// Purpose: fetch path model that presents opcode words to the decoder
// Assumes: words change at the falling edge, one word per cycle
// Notes: idle cycles carry a junk word with valid low
`timescale 1ns/1ns
module fetch_model (
    // clock
    input wire logic clk_sys,
    // fetch side
    output opdec_pkg::dec_in_s fetch_in
);
    import opdec_pkg::*;

    initial fetch_in = '0;

    // one word; r bit is shared by both register fields
    task automatic send(input logic [15:0] w, input logic [2:0] f);
        @(negedge clk_sys);
        fetch_in <= {1'b1, w, f};
    endtask : send

    task automatic idle(input logic [15:0] junk);
        @(negedge clk_sys);
        fetch_in <= {1'b0, junk, 3'h0};
    endtask : idle
endmodule : fetch_model

// >>> sim/tb_opdec_top.sv
// Purpose: self-checking bench for the opcode decoder
// Assumes: one-cycle latency, counts picked by fast and aligned/taken
// Notes: expected results queue up in issue order
`timescale 1ns/1ns
module tb_opdec_top;
    import opdec_pkg::*;

    localparam logic [7:0] RD = 8'h01, SR = 8'h02, KO = 8'h04, CO = 8'h08;
    localparam logic [7:0] DI = 8'h10, EX = 8'h20, ST = 8'h40, VA = 8'h80;
    localparam logic [2:0] pf[6] = '{3'h4, 3'h0, 3'h5, 3'h6, 3'h1, 3'h2};
    localparam logic [3:0] bn[6] = '{4'h8, 4'ha, 4'h0, 4'h2, 4'h4, 4'h6};
    localparam logic [15:0] ill[4] = '{16'h0f10, 16'h0f01, 16'hdf1b,
        16'hfe00};

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    dec_in_s fetch_in;
    dec_out_s dec_out_r;
    int errors = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h107acdd9;
    logic [2:0] fl = 3'h7;
    dec_out_s eq[$];
    logic [7:0] mq[$];

    always #5 clk_sys = ~clk_sys;

    opdec_top opdec_top_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .fetch_in(fetch_in),
        .dec_out_r(dec_out_r)
    );

    fetch_model fetch_model_inst (
        .clk_sys(clk_sys),
        .fetch_in(fetch_in)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic c(input string n, input logic [7:0] x,
        input logic [7:0] g);
        checks_done++;
        if (x !== g) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask : c

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // st bytes: fast and slow count of first pair, then of second pair
    task automatic go(input logic [15:0] w, input op_class_e op,
        input logic [7:0] m, input logic [7:0] kx, input logic [31:0] st);
        dec_out_s e;
        logic [31:0] r;
        e = '0;
        e.valid = 1'b1;
        e.illegal = (op == op_none);
        e.op = op;
        e.rfile = w[4];
        e.dst = w[3:0];
        e.src = w[8:5];
        e.konst = kx[4:0];
        e.cond = w[11:8];
        e.disp = w[7:0];
        e.ext_words = kx[6:5];
        e.imm_long = kx[7];
        e.variant = w[7:5];
        r = (fl[2] & fl[1]) ? st : {st[15:0], 16'h0};
        e.states = fl[0] ? r[29:24] : r[21:16];
        eq.push_back(e);
        mq.push_back(m);
        fetch_model_inst.send(w, fl);
        r = rnd();
        if (r[1:0] == 2'h0) fetch_model_inst.idle(r[31:16]);
    endtask : go

    always @(posedge clk_sys) begin : watch
        dec_out_s e;
        logic [7:0] m;
        #1;
        if (rst_n === 1'b1 && dec_out_r.valid !== 1'b0) begin
            if (dec_out_r.valid !== 1'b1 || eq.size() == 0) begin
                c("valid", 8'h00, 8'h01);
            end else begin
                e = eq.pop_front();
                m = mq.pop_front();
                c("illegal", e.illegal, dec_out_r.illegal);
                c("op", e.op, dec_out_r.op);
                if (m[0]) c("rfile", e.rfile, dec_out_r.rfile);
                if (m[0]) c("dst", e.dst, dec_out_r.dst);
                if (m[1]) c("src", e.src, dec_out_r.src);
                if (m[2]) c("konst", e.konst, dec_out_r.konst);
                if (m[3]) c("cond", e.cond, dec_out_r.cond);
                if (m[4]) c("disp", e.disp, dec_out_r.disp);
                if (m[5]) c("ext", e.ext_words, dec_out_r.ext_words);
                if (m[5]) c("long", e.imm_long, dec_out_r.imm_long);
                if (m[6]) c("states", e.states, dec_out_r.states);
                if (m[7]) c("variant", e.variant, dec_out_r.variant);
            end
        end
    end

    initial begin : main
        int i;
        logic [31:0] s;
        repeat (12) @(posedge clk_sys);
        c("reset", 8'h01, {7'h0, dec_out_r === '0});
        @(negedge clk_sys);
        rst_n = 1'b1;
        for (i = 0; i < 6; i++) begin
            s = rnd();
            fl = s[31:29];
            go({4'he, 3'h3, s[8:0]}, op_pw_compare, RD | SR | ST, 8'h00,
                32'h01040104);
            go({4'he, 3'h4, s[8:0]}, op_xy_convert, RD | SR | ST, 8'h00,
                32'h03060306);
            go({4'hf, 3'h3, s[8:0]}, op_draw_step, RD | SR, 8'h00, 0);
            go({4'hf, pf[i], s[8:0]}, op_pix_xfer, RD | SR, 8'h00, 0);
            go({8'h0f, bn[i], 4'h0}, op_blk_copy, VA, 8'h00, 0);
        end
        go(16'h0fc0, op_fill_lin, 8'h00, 8'h00, 0);
        go(16'h0fe0, op_fill_xy, 8'h00, 8'h00, 0);
        go(16'hdf1a, op_line, 8'h00, 8'h00, 0);
        go(16'hdf9a, op_line, 8'h00, 8'h00, 0);
        $display("test graphics done");
        for (i = 0; i < 4; i++) begin
            s = rnd();
            fl = s[31:29];
            fl[1] = 1'b1;
            go({11'h04b, s[4:0]}, op_sub_ret, KO | ST, {3'h0, s[4:0]},
                32'h070a070a);
            go({11'h048, s[4:0]}, op_trap, KO | ST, {3'h0, s[4:0]},
                32'h10131e21);
            go({11'h001, s[4:0]}, op_rev_query, RD | ST, 8'h00,
                32'h01040104);
            go({6'h01, s[5], 3'h5, s[5], s[4:0]}, op_field_load, 8'h00,
                8'h00, 0);
            go({11'h00b, s[4:0]}, op_jump_reg, RD | ST, 8'h00,
                32'h02050205);
        end
        $display("test control done");
        for (i = 0; i < 6; i++) begin
            s = rnd();
            fl = s[31:29];
            fl[2] = 1'b1;
            go({4'hc, s[11:8], 8'h80}, op_jump_abs, CO | EX | ST, 8'h40,
                32'h03060407);
            go({4'hc, s[11:8], 8'h00}, op_jump_rel, CO | EX | ST, 8'h20,
                32'h03060104);
            go({4'hc, s[11:1], 1'b1}, op_jump_short, CO | DI | ST, 8'h00,
                32'h02050205);
            go({11'h06c, s[4:0]}, op_dsj, RD | EX | ST, 8'h20,
                32'h03090208);
            go({11'h06d, s[4:0]}, op_dsj_eq, RD | EX | ST, 8'h20,
                32'h03090208);
            go({11'h06e, s[4:0]}, op_dsj_ne, RD | EX | ST, 8'h20,
                32'h03090208);
            go({5'h07, s[10:0]}, op_dsj_short, RD | ST, 8'h00,
                32'h02050306);
        end
        $display("test jumps done");
        for (i = 0; i < 4; i++) begin
            s = rnd();
            fl = s[31:29];
            go({4'h2, i[1:0], s[9:0]}, op_shift_k, RD | KO | ST,
                {3'h0, s[9:5]}, (i == 0) ? 32'h03060306 : 32'h01040104);
            go({5'h0c, i[1:0], s[8:0]}, op_shift_r, RD | SR | ST, 8'h00,
                (i == 0) ? 32'h03060306 : 32'h01040104);
        end
        go({6'h0c, s[9:0]}, op_shift_k, RD | KO | ST, {3'h0, s[9:5]},
            32'h01040104);
        go({7'h34, s[8:0]}, op_shift_r, RD | SR | ST, 8'h00,
            32'h01040104);
        $display("test shifts done");
        go({11'h058, s[4:0]}, op_imm, RD | EX, 8'h20, 0);
        go({11'h059, s[4:0]}, op_imm, RD | EX, 8'hc0, 0);
        go({11'h05c, s[4:0]}, op_imm, RD | EX, 8'hc0, 0);
        for (i = 0; i < 4; i++) begin
            go(ill[i], op_none, 8'h00, 8'h00, 0);
        end
        repeat (4) fetch_model_inst.idle(16'h0960);
        c("pending", 8'h00, eq.size());
        $display("test immediates and illegal done");
        conclude();
    end

    initial begin : watchdog
        #50000;
        errors++;
        conclude();
    end
endmodule : tb_opdec_top
